// >>> logic/regstack_regs.svh
// Constants for the 16x4 register stack with output register.
// Assumes inclusion by bare name from the stack's design files.
`ifndef REGSTACK_REGS_SVH
`define REGSTACK_REGS_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define RS_WORDS 16
`define RS_ADDR_W 4
`define RS_WIDTH 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RS_OUT_RST 4'h0
`define RS_OE_N_RST 1'b1
`define RS_EDGE_RST 1'b1

`endif

// >>> logic/regstack_pkg.sv
// Types shared by the 16x4 register stack files.
// Assumes regstack_regs.svh is on the include path.
`include "regstack_regs.svh"

package regstack_pkg;

  // ----------------------------------------------------------------------
  // Host control lines, all active low
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic write_en_n;
    logic chip_sel_n;
    logic out_en_n;
  } host_ctrl_t;

  // ----------------------------------------------------------------------
  // Output register load selection
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LOAD_HOLD,
    LOAD_WORD,
    LOAD_THRU
  } load_sel_t;

endpackage

// >>> logic/regstack_array.sv
// Storage array of the register stack: one write port, one read port.
// Assumes write enable already qualified by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "regstack_regs.svh"

module regstack_array
  import regstack_pkg::*;
#(
  parameter int WORDS = `RS_WORDS,
  parameter int ADDR_W = `RS_ADDR_W,
  parameter int WIDTH = `RS_WIDTH
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  if (WORDS != (1 << ADDR_W)) begin : g_bad_words
    $error("WORDS must equal 2**ADDR_W");
  end

  // ----------------------------------------------------------------------
  // Array, no reset: contents undefined until written
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [WORDS];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_q[rd_addr];

endmodule

`default_nettype wire

// >>> logic/regstack.sv
// Top of the 16x4 register stack with clocked output register.
// Assumes host pins synchronous to core_clk; edge_clock is a sampled pin.
//
// Behaviour
// - Sixteen 4-bit words, 64 bits total, chosen by a 4-bit index.
// - Write data into addressed word while write, select and clock low.
// - During that write window the word follows changes on data inputs.
// - Rising clock, selected, write high: addressed word loads output register.
// - Rising clock, selected, write low: input data loads output register.
// - Output register holds its value until next qualifying rising clock.
// - Output enable registered onto read_bits_oe_n; read_bits always drive output register.
`timescale 1ns/1ps
`default_nettype none
`include "regstack_regs.svh"

module regstack
  import regstack_pkg::*;
#(
  parameter int WORDS = `RS_WORDS,
  parameter int ADDR_W = `RS_ADDR_W,
  parameter int WIDTH = `RS_WIDTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic edge_clock,
  input wire host_ctrl_t host_ctrl,
  input wire logic [ADDR_W-1:0] word_index,
  input wire logic [WIDTH-1:0] write_bits,
  output logic [WIDTH-1:0] read_bits,
  output logic read_bits_oe_n
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (WORDS != (1 << ADDR_W)) begin : g_bad_words
    $error("WORDS must equal 2**ADDR_W");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least one");
  end

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  function automatic logic write_window(input host_ctrl_t c,
                                        input logic clk_level);
    write_window = !c.write_en_n && !c.chip_sel_n && !clk_level;
  endfunction

  function automatic load_sel_t load_select(input host_ctrl_t c,
                                            input logic rise);
    if (!rise || c.chip_sel_n) begin
      load_select = LOAD_HOLD;
    end else if (c.write_en_n) begin
      load_select = LOAD_WORD;
    end else begin
      load_select = LOAD_THRU;
    end
  endfunction

  logic edge_clock_q;
  logic [WIDTH-1:0] read_bits_q;
  logic [WIDTH-1:0] read_bits_d;
  logic read_oe_n_q;
  logic [WIDTH-1:0] word_data;
  wire logic clk_rise;
  wire logic wr_en;
  wire load_sel_t load_sel;

  // Level write, repeated each cycle so the word tracks the data
  assign wr_en = write_window(host_ctrl, edge_clock);
  assign clk_rise = edge_clock && !edge_clock_q;
  assign load_sel = load_select(host_ctrl, clk_rise);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  regstack_array #(
    .WORDS(WORDS),
    .ADDR_W(ADDR_W),
    .WIDTH(WIDTH)
  ) u_array (
    .core_clk(core_clk),
    .wr_en(wr_en),
    .wr_addr(word_index),
    .wr_data(write_bits),
    .rd_addr(word_index),
    .rd_data(word_data)
  );

  // ----------------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------------
  always_comb begin
    case (load_sel)
      LOAD_WORD: read_bits_d = word_data;
      LOAD_THRU: read_bits_d = write_bits;
      LOAD_HOLD: read_bits_d = read_bits_q;
      default: read_bits_d = read_bits_q;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      edge_clock_q <= `RS_EDGE_RST;
      read_bits_q <= WIDTH'(`RS_OUT_RST);
      read_oe_n_q <= `RS_OE_N_RST;
    end else begin
      edge_clock_q <= edge_clock;
      read_bits_q <= read_bits_d;
      read_oe_n_q <= host_ctrl.out_en_n;
    end
  end

  // Enable follows pin level only, regardless of edge_clock
  assign read_bits = read_bits_q;
  assign read_bits_oe_n = read_oe_n_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_index_holds_word;
    @(posedge core_clk) disable iff (!rstn)
      (!$past(wr_en) && $stable(word_index)) |-> $stable(word_data);
  endproperty
  a_index_holds_word: assert property (p_index_holds_word)
    else $error("Stored word changed without a write");

  property p_write_stores;
    @(posedge core_clk) disable iff (!rstn)
      (!host_ctrl.write_en_n && !host_ctrl.chip_sel_n && !edge_clock)
      ##1 $stable(word_index) |-> word_data == $past(write_bits);
  endproperty
  a_write_stores: assert property (p_write_stores)
    else $error("Write window did not store data");

  property p_write_tracks;
    @(posedge core_clk) disable iff (!rstn)
      (wr_en [*2]) ##1 $stable(word_index)
      |-> word_data == $past(write_bits);
  endproperty
  a_write_tracks: assert property (p_write_tracks)
    else $error("Word did not follow data during write");

  property p_read_load;
    @(posedge core_clk) disable iff (!rstn)
      (edge_clock && !$past(edge_clock) && !host_ctrl.chip_sel_n
       && host_ctrl.write_en_n) |=> read_bits == $past(word_data);
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("Rising edge read did not load word");

  property p_thru_load;
    @(posedge core_clk) disable iff (!rstn)
      (edge_clock && !$past(edge_clock) && !host_ctrl.chip_sel_n
       && !host_ctrl.write_en_n) |=> read_bits == $past(write_bits);
  endproperty
  a_thru_load: assert property (p_thru_load)
    else $error("Rising edge write did not pass data through");

  property p_hold_no_edge;
    @(posedge core_clk) disable iff (!rstn)
      !(edge_clock && !edge_clock_q) |=> $stable(read_bits);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge)
    else $error("Output register changed without rising edge");

  property p_oe_follows;
    @(posedge core_clk) disable iff (!rstn)
      rstn |=> read_bits_oe_n == $past(host_ctrl.out_en_n);
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("Output enable not following pin");

  property p_deselect_hold;
    @(posedge core_clk) disable iff (!rstn)
      host_ctrl.chip_sel_n |=> $stable(read_bits);
  endproperty
  a_deselect_hold: assert property (p_deselect_hold)
    else $error("Output loaded while deselected");

  property p_no_write_blocked;
    @(posedge core_clk) disable iff (!rstn)
      (host_ctrl.chip_sel_n || edge_clock) ##1 $stable(word_index)
      |-> $stable(word_data);
  endproperty
  a_no_write_blocked: assert property (p_no_write_blocked)
    else $error("Array written while deselected or clock high");

  property p_thru_no_store;
    @(posedge core_clk) disable iff (!rstn)
      (edge_clock && !host_ctrl.chip_sel_n && !host_ctrl.write_en_n)
      ##1 $stable(word_index) |-> $stable(word_data);
  endproperty
  a_thru_no_store: assert property (p_thru_no_store)
    else $error("Pass-through load also wrote the array");

  property p_oe_steady;
    @(posedge core_clk) disable iff (!rstn)
      rstn && $past(rstn) && $stable(host_ctrl.out_en_n)
      |=> $stable(read_bits_oe_n);
  endproperty
  a_oe_steady: assert property (p_oe_steady)
    else $error("Output enable moved with steady pin");

  property p_high_clock_hold;
    @(posedge core_clk) disable iff (!rstn)
      edge_clock && $past(edge_clock) |=> $stable(read_bits);
  endproperty
  a_high_clock_hold: assert property (p_high_clock_hold)
    else $error("Output register reloaded while clock stayed high");

  property p_reset_values;
    @(posedge core_clk)
      (!rstn ##1 !rstn) |-> read_bits == WIDTH'(`RS_OUT_RST)
        && read_bits_oe_n == `RS_OE_N_RST;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("Outputs not at reset values during reset");

endmodule

`default_nettype wire

// >>> tb/regstack_host.sv
// Host model that drives the stack's address, data and control pins.
// Assumes its pins change only just after a core_clk rising edge.
`timescale 1ns/1ps
`default_nettype none

module regstack_host
  import regstack_pkg::*;
(
  input wire logic core_clk,
  output logic edge_clock,
  output host_ctrl_t host_ctrl,
  output logic [3:0] word_index,
  output logic [3:0] write_bits
);
  initial begin
    edge_clock = 1'b1;
    host_ctrl = 3'b111;
    word_index = 4'h0;
    write_bits = 4'h0;
  end

  // ----
  // One cycle of pin levels
  // ----
  task automatic cyc(input logic ec, input logic we_n, input logic cs_n,
                     input logic [3:0] idx, input logic [3:0] d);
    @(posedge core_clk);
    edge_clock <= ec;
    host_ctrl.write_en_n <= we_n;
    host_ctrl.chip_sel_n <= cs_n;
    word_index <= idx;
    write_bits <= d;
  endtask

  task automatic set_oe(input logic oe_n);
    @(posedge core_clk);
    host_ctrl.out_en_n <= oe_n;
  endtask
endmodule
`default_nettype wire

// >>> tb/regstack_bench.sv
// Self-checking bench for the 16x4 register stack.
// Assumes the host model drives all pins except core_clk and rstn.
`timescale 1ns/1ps
`default_nettype none

module regstack_bench;
  import regstack_pkg::*;
  typedef struct packed {
    logic [1:0] op;
    logic [3:0] idx;
    logic [3:0] d;
    logic [3:0] e;
  } row_t;
  logic core_clk, rstn, edge_clock, read_bits_oe_n;
  host_ctrl_t host_ctrl;
  logic [3:0] word_index, write_bits, read_bits;
  int bad_count, num_checks;
  row_t rows [10];

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  regstack regstack_inst(.core_clk(core_clk), .rstn(rstn),
    .edge_clock(edge_clock), .host_ctrl(host_ctrl),
    .word_index(word_index), .write_bits(write_bits),
    .read_bits(read_bits), .read_bits_oe_n(read_bits_oe_n));
  regstack_host regstack_host_inst(.core_clk(core_clk),
    .edge_clock(edge_clock), .host_ctrl(host_ctrl),
    .word_index(word_index), .write_bits(write_bits));

  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [3:0] e,
                     input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [3:0] d);
    regstack_host_inst.cyc(1'b0, 1'b0, 1'b0, idx, d);
    regstack_host_inst.cyc(1'b0, 1'b1, 1'b1, idx, d);
  endtask

  // Low then rising edge_clock, then wait for the output register
  task automatic ld(input logic [3:0] idx, input logic we_n,
                    input logic [3:0] d, input logic cs_n);
    regstack_host_inst.cyc(1'b0, we_n, cs_n, idx, d);
    regstack_host_inst.cyc(1'b1, we_n, cs_n, idx, d);
    regstack_host_inst.cyc(1'b1, 1'b1, 1'b1, idx, d);
    @(posedge core_clk);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rstn = 1'b0;
    rows = '{'{2'd0, 4'h3, 4'h5, 4'h0}, '{2'd0, 4'hc, 4'ha, 4'h0},
             '{2'd1, 4'h3, 4'h0, 4'h5}, '{2'd1, 4'hc, 4'h0, 4'ha},
             '{2'd2, 4'h7, 4'h9, 4'h9}, '{2'd1, 4'h7, 4'h0, 4'h9},
             '{2'd0, 4'h0, 4'hf, 4'h0}, '{2'd1, 4'h0, 4'h6, 4'hf},
             '{2'd0, 4'hf, 4'h1, 4'h0}, '{2'd1, 4'hf, 4'h0, 4'h1}};
    repeat (3) @(posedge core_clk);
    #1;
    chk("reset read_bits", 4'h0, read_bits);
    chk("reset oe_n", 4'h1, {3'b000, read_bits_oe_n});
    $display("reset checks done");
    @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].op == 2'd0)
        wr(rows[i].idx, rows[i].d);
      else begin
        ld(rows[i].idx, rows[i].op == 2'd1 ? 1'b1 : 1'b0, rows[i].d, 1'b0);
        chk("row read_bits", rows[i].e, read_bits);
      end
    end
    $display("table done");
    wr(4'h3, 4'h6);
    @(posedge core_clk);
    #1;
    chk("held read_bits", 4'h1, read_bits);
    ld(4'h3, 1'b1, 4'h0, 1'b0);
    chk("written word", 4'h6, read_bits);
    wr(4'h5, 4'h1);
    regstack_host_inst.cyc(1'b0, 1'b0, 1'b0, 4'h5, 4'h4);
    regstack_host_inst.cyc(1'b0, 1'b0, 1'b0, 4'h5, 4'h2);
    ld(4'h5, 1'b1, 4'h0, 1'b0);
    chk("tracked word", 4'h2, read_bits);
    $display("write tests done");
    regstack_host_inst.cyc(1'b0, 1'b0, 1'b1, 4'h3, 4'hb);
    regstack_host_inst.cyc(1'b1, 1'b1, 1'b1, 4'h3, 4'hb);
    regstack_host_inst.cyc(1'b1, 1'b0, 1'b0, 4'h3, 4'hd);
    regstack_host_inst.cyc(1'b1, 1'b0, 1'b0, 4'h3, 4'he);
    ld(4'h3, 1'b1, 4'h0, 1'b1);
    chk("deselected load", 4'h2, read_bits);
    ld(4'h3, 1'b1, 4'h0, 1'b0);
    chk("blocked writes", 4'h6, read_bits);
    $display("deselect tests done");
    regstack_host_inst.set_oe(1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    chk("oe_n low", 4'h0, {3'b000, read_bits_oe_n});
    regstack_host_inst.set_oe(1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    chk("oe_n high", 4'h1, {3'b000, read_bits_oe_n});
    $display("enable tests done");
    // Mid-run reset with enable pin low: outputs return to reset state
    regstack_host_inst.set_oe(1'b0);
    rstn <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("mid reset read_bits", 4'h0, read_bits);
    chk("mid reset oe_n", 4'h1, {3'b000, read_bits_oe_n});
    @(posedge core_clk);
    rstn <= 1'b1;
    ld(4'h3, 1'b1, 4'h0, 1'b0);
    chk("word after reset", 4'h6, read_bits);
    chk("oe_n after reset", 4'h0, {3'b000, read_bits_oe_n});
    $display("mid reset tests done");
    end_sim();
  end
endmodule
`default_nettype wire
